// ---- hdl/svsog_regs.svh ----
/*
 * register map, field positions, reset values and selector codes of the
 * servo status-output and gain-table block.
 * assumes: included by bare name; definitions only.
 */
`ifndef SVSOG_REGS_SVH
`define SVSOG_REGS_SVH

// byte addresses of the apb registers
`define SVSOG_ADDR_CTRL      12'h000
`define SVSOG_ADDR_RUN_THR   12'h004
`define SVSOG_ADDR_TRQ_LIM   12'h008
`define SVSOG_ADDR_TRQ_THR   12'h00C
`define SVSOG_ADDR_TORQUE    12'h010
`define SVSOG_ADDR_SPEED     12'h014
`define SVSOG_ADDR_GAINS     12'h018
`define SVSOG_ADDR_STATUS    12'h01C
`define SVSOG_ADDR_IRQ_STAT  12'h020
`define SVSOG_ADDR_IRQ_MASK  12'h024
`define SVSOG_ADDR_INERTIA   12'h028

// control register fields
`define SVSOG_CTRL_SEL_LO    0
`define SVSOG_CTRL_SEL_HI    3
`define SVSOG_CTRL_STF_LO    4
`define SVSOG_CTRL_STF_HI    7
`define SVSOG_CTRL_RAT_LO    8
`define SVSOG_CTRL_RAT_HI    9
`define SVSOG_CTRL_ENA       10
`define SVSOG_CTRL_FAULT     11
`define SVSOG_CTRL_TUNE_OK   12

// gains register fields
`define SVSOG_GAIN_KP_LO     0
`define SVSOG_GAIN_KP_HI     8
`define SVSOG_GAIN_TI_LO     16
`define SVSOG_GAIN_TI_HI     25

// reset values
`define SVSOG_RST_SEL        4'h0
`define SVSOG_RST_STF        4'h5
`define SVSOG_RST_RAT        2'h3
`define SVSOG_RST_THR        16'h0000
`define SVSOG_RST_INERTIA    16'h0000

// selector codes
`define SVSOG_SEL_INPOS      4'h0
`define SVSOG_SEL_RUN        4'h1
`define SVSOG_SEL_CLAMP      4'h3
`define SVSOG_SEL_INDEX      4'h5
`define SVSOG_SEL_ENERGY     4'h7
`define SVSOG_SEL_TRQ        4'h9

// interrupt status bits
`define SVSOG_IRQ_FAULT      0
`define SVSOG_IRQ_INPOS      1
`define SVSOG_IRQ_W          2

`endif

// ---- hdl/svsog_pkg.sv ----
/*
 * types of the servo status-output and gain-table block.
 * assumes: compiled before every module of the block.
 */
package svsog_pkg;
    typedef logic [3:0]  svsog_level_t;   // stiffness level 0..15
    typedef logic [8:0]  svsog_kp_t;      // position loop gain, 1/s
    typedef logic [11:0] svsog_kv_t;      // speed loop gain, Hz
    typedef logic [9:0]  svsog_ti_t;      // integral time, 0.25 ms units
    typedef enum logic [1:0] {
        SVSOG_NORMAL,
        SVSOG_ALARM,
        SVSOG_WAIT_CLR
    } svsog_fault_t;
endpackage

// ---- hdl/svsog_gain_lut.sv ----
/*
 * stiffness lookup: level to position gain, speed gain and integral time.
 * assumes: level and ratio come from registers on the same clock; purely
 * combinational.
 */
`timescale 1ns/100ps
`include "svsog_regs.svh"

module svsog_gain_lut (
    input  wire svsog_pkg::svsog_level_t level,    // stiffness level
    input  wire logic [1:0]              ratio,    // speed gain ratio
    output svsog_pkg::svsog_kp_t         kp,       // position loop gain
    output svsog_pkg::svsog_kv_t         kv,       // speed loop gain
    output svsog_pkg::svsog_ti_t         ti        // integral time
);
    // position gain per level
    function automatic svsog_pkg::svsog_kp_t kp_of(input svsog_pkg::svsog_level_t l);
        case (l)
            4'h0: kp_of = 9'h00A;
            4'h1: kp_of = 9'h00F;
            4'h2: kp_of = 9'h014;
            4'h3: kp_of = 9'h019;
            4'h4: kp_of = 9'h01E;
            4'h5: kp_of = 9'h028;
            4'h6: kp_of = 9'h041;
            4'h7: kp_of = 9'h050;
            4'h8: kp_of = 9'h064;
            4'h9: kp_of = 9'h078;
            4'hA: kp_of = 9'h08C;
            4'hB: kp_of = 9'h0A0;
            4'hC: kp_of = 9'h0B4;
            4'hD: kp_of = 9'h0D2;
            4'hE: kp_of = 9'h0FA;
            default: kp_of = 9'h12C;
        endcase
    endfunction

    // integral time per level
    function automatic svsog_pkg::svsog_ti_t ti_of(input svsog_pkg::svsog_level_t l);
        case (l)
            4'h0: ti_of = 10'h320;
            4'h1: ti_of = 10'h258;
            4'h2: ti_of = 10'h1C2;
            4'h3: ti_of = 10'h190;
            4'h4: ti_of = 10'h12C;
            4'h5: ti_of = 10'h0C8;
            4'h6: ti_of = 10'h08C;
            4'h7: ti_of = 10'h06E;
            4'h8: ti_of = 10'h05A;
            4'h9: ti_of = 10'h050;
            4'hA: ti_of = 10'h046;
            4'hB: ti_of = 10'h03C;
            4'hC: ti_of = 10'h037;
            4'hD: ti_of = 10'h032;
            4'hE: ti_of = 10'h028;
            default: ti_of = 10'h01E;
        endcase
    endfunction

    // speed gain = kp * (ratio + 1)
    always_comb begin
        kp = kp_of(level);
        ti = ti_of(level);
        kv = 12'({3'h0, kp} * ({10'h000, ratio} + 12'h001));
    end
endmodule

// ---- hdl/svsog_sync.sv ----
/*
 * two flip-flop synchroniser bank for pin inputs.
 * assumes: inputs asynchronous to mclk; reset value low.
 */
`timescale 1ns/100ps

module svsog_sync #(
    parameter int W = 1                  // number of bits
) (
    input  wire logic         mclk,      // clock
    input  wire logic         rst_n,     // async reset, active low
    input  wire logic [W-1:0] d,         // asynchronous inputs
    output logic      [W-1:0] q          // synchronised outputs
);
    typedef struct packed {
        logic [W-1:0] s1;                // first stage, read by s2 only
        logic [W-1:0] s2;                // second stage
    } svsog_sync_t;

    svsog_sync_t st;
    svsog_sync_t next_st;

    // shift one stage per clock
    always_comb begin
        next_st    = st;
        next_st.s1 = d;
        next_st.s2 = st.s1;
    end

    // register state
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign q = st.s2;
endmodule

// ---- hdl/svsog_top.sv ----
/*
 * servo status outputs and gain table: fault indicator with clear input,
 * selectable active-low status terminal, stiffness gain lookup, apb registers
 * and a level interrupt.
 * assumes: apb master on mclk; pins fault_clear_in and index_pulse_in are
 * asynchronous; fault_detect, in_position, torque_cmd and motor_speed come
 * from logic on mclk.
 */
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
`include "svsog_regs.svh"

//Operation
// - fault output low normal, high alarmed
// - code 0 signals positioning complete
// - code 1 signals speed above threshold
// - code 5 passes encoder index pulse
// - code 7 signals drive enabled, energized
// - code 9 signals torque above threshold
// - sixteen stiffness levels set three gains
// - stiffness level resets to five
// - speed gain is kp times ratio+1
// - lookup values, integral time 0.25ms units
// - manual inertia used when tuning unsuitable
module svsog_top (
    input  wire logic        mclk,                // 250 MHz clock
    input  wire logic        rst_n,               // async reset, active low
    input  wire logic        psel,                // apb select
    input  wire logic        penable,             // apb access phase
    input  wire logic        pwrite,              // apb write
    input  wire logic [11:0] paddr,               // apb byte address
    input  wire logic [31:0] pwdata,              // apb write data
    output logic      [31:0] prdata,              // apb read data
    output logic             pready,              // apb ready
    output logic             pslverr,             // apb error
    input  wire logic        fault_detect,        // abnormal condition seen
    input  wire logic        fault_clear_in,      // clear pin, active low
    input  wire logic        in_position,         // positioning complete
    input  wire logic [15:0] torque_cmd,          // internal torque command
    input  wire logic [15:0] motor_speed,         // motor speed magnitude
    input  wire logic        index_pulse_in,      // encoder index pulse pin
    output logic             fault_indicator_out, // high while alarmed
    output logic             status_out_n,        // selected terminal, low = on
    output logic             irq,                 // level interrupt
    output logic [8:0]       position_loop_gain,  // active position gain
    output logic [11:0]      speed_loop_gain,     // active speed gain
    output logic [9:0]       speed_integral_time, // active integral time
    output logic [15:0]      load_inertia_ratio   // inertia used by the loop
);
    typedef struct packed {
        svsog_pkg::svsog_fault_t fsm;            // fault state
        logic [3:0]              sel;            // output function select
        svsog_pkg::svsog_level_t stf;            // stiffness level
        logic [1:0]              rat;            // speed gain ratio
        logic                    ena;            // drive enable
        logic                    tune_ok;        // autotuning suitable
        logic [15:0]             run_thr;        // running speed threshold
        logic [15:0]             trq_lim;        // torque clamp limit
        logic [15:0]             trq_thr;        // torque detect threshold
        logic [15:0]             inertia;        // manual inertia percent
        logic [15:0]             est_inertia;    // estimated inertia
        logic [`SVSOG_IRQ_W-1:0] ist;            // sticky interrupt status
        logic [`SVSOG_IRQ_W-1:0] imask;          // interrupt mask
        logic                    inpos_d;        // last in_position
        logic                    fault_o;        // fault output flop
        logic                    stat_n;         // status output flop
        logic                    irq_o;          // interrupt flop
        logic [8:0]              kp;             // registered gains
        logic [11:0]             kv;
        logic [9:0]              ti;
        logic [15:0]             inert_o;        // registered inertia out
        logic [31:0]             rdata;          // read data
        logic                    rdy;            // apb ready
        logic                    err;            // apb error
    } svsog_state_t;

    svsog_state_t st;
    svsog_state_t next_st;

    logic [1:0]              pins_s;   // synchronised pins
    logic                    clr_s;    // clear asserted, synchronised
    logic                    idx_s;    // index pulse, synchronised
    svsog_pkg::svsog_kp_t    lut_kp;   // lookup results
    svsog_pkg::svsog_kv_t    lut_kv;
    svsog_pkg::svsog_ti_t    lut_ti;

    // pin inputs pass two flops before use
    svsog_sync #(.W(2)) i_svsog_sync (
        .mclk  (mclk),
        .rst_n (rst_n),
        .d     ({~fault_clear_in, index_pulse_in}),
        .q     (pins_s)
    );
    assign clr_s = pins_s[1];
    assign idx_s = pins_s[0];

    // stiffness lookup
    svsog_gain_lut i_svsog_gain_lut (
        .level (st.stf),
        .ratio (st.rat),
        .kp    (lut_kp),
        .kv    (lut_kv),
        .ti    (lut_ti)
    );

    // known apb address
    function automatic logic addr_ok(input logic [11:0] a);
        case (a)
            `SVSOG_ADDR_CTRL, `SVSOG_ADDR_RUN_THR, `SVSOG_ADDR_TRQ_LIM,
            `SVSOG_ADDR_TRQ_THR, `SVSOG_ADDR_TORQUE, `SVSOG_ADDR_SPEED,
            `SVSOG_ADDR_GAINS, `SVSOG_ADDR_STATUS, `SVSOG_ADDR_IRQ_STAT,
            `SVSOG_ADDR_IRQ_MASK, `SVSOG_ADDR_INERTIA: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    endfunction

    // status condition per selector code; unused codes read false
    function automatic logic cond_of(input logic [3:0] s, input logic ip, input logic run,
                                     input logic clp, input logic ix, input logic en,
                                     input logic tq);
        case (s)
            `SVSOG_SEL_INPOS:  cond_of = ip;
            `SVSOG_SEL_RUN:    cond_of = run;
            `SVSOG_SEL_CLAMP:  cond_of = clp;
            `SVSOG_SEL_INDEX:  cond_of = ix;
            `SVSOG_SEL_ENERGY: cond_of = en;
            `SVSOG_SEL_TRQ:    cond_of = tq;
            default:           cond_of = 1'b0;
        endcase
    endfunction

    logic                    alarmed;   // fault state is not normal
    logic                    running;   // speed above threshold
    logic                    clamped;   // torque command above limit
    logic                    trq_over;  // torque above detect threshold
    logic                    energized; // enabled and not alarmed
    logic                    wr;        // apb write access
    logic [`SVSOG_IRQ_W-1:0] ev;        // interrupt events this cycle
    logic [31:0]             ctrl_rd;   // control read image

    // next state
    always_comb begin
        next_st   = st;
        alarmed   = (st.fsm != svsog_pkg::SVSOG_NORMAL);
        running   = (motor_speed > st.run_thr);
        clamped   = (torque_cmd > st.trq_lim);
        trq_over  = (torque_cmd > st.trq_thr);
        energized = st.ena && !alarmed;
        wr        = psel && penable && pwrite && !st.rdy;
        ev        = '0;
        ctrl_rd   = '0;
        ctrl_rd[`SVSOG_CTRL_SEL_HI:`SVSOG_CTRL_SEL_LO] = st.sel;
        ctrl_rd[`SVSOG_CTRL_STF_HI:`SVSOG_CTRL_STF_LO] = st.stf;
        ctrl_rd[`SVSOG_CTRL_RAT_HI:`SVSOG_CTRL_RAT_LO] = st.rat;
        ctrl_rd[`SVSOG_CTRL_ENA]     = st.ena;
        ctrl_rd[`SVSOG_CTRL_FAULT]   = alarmed;
        ctrl_rd[`SVSOG_CTRL_TUNE_OK] = st.tune_ok;

        // fault state: alarm holds until cause gone and clear asserted
        case (st.fsm)
            svsog_pkg::SVSOG_NORMAL: begin
                if (fault_detect) begin
                    next_st.fsm = svsog_pkg::SVSOG_ALARM;
                    ev[`SVSOG_IRQ_FAULT] = 1'b1;
                end
            end
            svsog_pkg::SVSOG_ALARM: begin
                // clear ignored while the cause remains
                if (!fault_detect && clr_s) begin
                    next_st.fsm = svsog_pkg::SVSOG_NORMAL;
                end
            end
            default: begin
                next_st.fsm = svsog_pkg::SVSOG_ALARM;
            end
        endcase

        // rising in-position is an event
        next_st.inpos_d = in_position;
        if (in_position && !st.inpos_d) begin
            ev[`SVSOG_IRQ_INPOS] = 1'b1;
        end

        // estimate only tracks while tuning is suitable
        if (st.tune_ok && running) begin
            next_st.est_inertia = st.inertia;
        end

        // apb: one wait state, answer in the second access cycle
        next_st.rdy = psel && penable && !st.rdy;
        next_st.err = psel && penable && !st.rdy && !addr_ok(paddr);
        next_st.rdata = '0;
        if (psel && penable && !st.rdy && !pwrite) begin
            case (paddr)
                `SVSOG_ADDR_CTRL:     next_st.rdata = ctrl_rd;
                `SVSOG_ADDR_RUN_THR:  next_st.rdata = {16'h0000, st.run_thr};
                `SVSOG_ADDR_TRQ_LIM:  next_st.rdata = {16'h0000, st.trq_lim};
                `SVSOG_ADDR_TRQ_THR:  next_st.rdata = {16'h0000, st.trq_thr};
                `SVSOG_ADDR_TORQUE:   next_st.rdata = {16'h0000, torque_cmd};
                `SVSOG_ADDR_SPEED:    next_st.rdata = {16'h0000, motor_speed};
                `SVSOG_ADDR_GAINS:    next_st.rdata = {6'h00, st.ti, 7'h00, st.kp};
                `SVSOG_ADDR_STATUS:   next_st.rdata = {26'h0, trq_over, energized, idx_s,
                                                       clamped, running, in_position};
                `SVSOG_ADDR_IRQ_STAT: next_st.rdata = {30'h0, st.ist};
                `SVSOG_ADDR_IRQ_MASK: next_st.rdata = {30'h0, st.imask};
                `SVSOG_ADDR_INERTIA:  next_st.rdata = {16'h0000, st.inertia};
                default:              next_st.rdata = '0;
            endcase
        end
        if (wr) begin
            case (paddr)
                `SVSOG_ADDR_CTRL: begin
                    next_st.sel     = pwdata[`SVSOG_CTRL_SEL_HI:`SVSOG_CTRL_SEL_LO];
                    next_st.stf     = pwdata[`SVSOG_CTRL_STF_HI:`SVSOG_CTRL_STF_LO];
                    next_st.rat     = pwdata[`SVSOG_CTRL_RAT_HI:`SVSOG_CTRL_RAT_LO];
                    next_st.ena     = pwdata[`SVSOG_CTRL_ENA];
                    next_st.tune_ok = pwdata[`SVSOG_CTRL_TUNE_OK];
                end
                `SVSOG_ADDR_RUN_THR:  next_st.run_thr = pwdata[15:0];
                `SVSOG_ADDR_TRQ_LIM:  next_st.trq_lim = pwdata[15:0];
                `SVSOG_ADDR_TRQ_THR:  next_st.trq_thr = pwdata[15:0];
                `SVSOG_ADDR_IRQ_STAT: next_st.ist     = st.ist & ~pwdata[`SVSOG_IRQ_W-1:0];
                `SVSOG_ADDR_IRQ_MASK: next_st.imask   = pwdata[`SVSOG_IRQ_W-1:0];
                `SVSOG_ADDR_INERTIA:  next_st.inertia = pwdata[15:0];
                default: begin
                end
            endcase
        end
        // set wins over write-one-to-clear
        next_st.ist = next_st.ist | ev;

        // registered outputs
        next_st.fault_o = (next_st.fsm != svsog_pkg::SVSOG_NORMAL);
        next_st.stat_n  = ~cond_of(st.sel, in_position, running, clamped, idx_s,
                                   energized, trq_over);
        next_st.irq_o   = |(next_st.ist & next_st.imask);
        next_st.kp      = lut_kp;
        next_st.kv      = lut_kv;
        next_st.ti      = lut_ti;
        next_st.inert_o = st.tune_ok ? st.est_inertia : st.inertia;
    end

    // register state
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st         <= '0;
            st.fsm     <= svsog_pkg::SVSOG_NORMAL;
            st.sel     <= `SVSOG_RST_SEL;
            st.stf     <= `SVSOG_RST_STF;
            st.rat     <= `SVSOG_RST_RAT;
            st.run_thr <= `SVSOG_RST_THR;
            st.trq_lim <= `SVSOG_RST_THR;
            st.trq_thr <= `SVSOG_RST_THR;
            st.inertia <= `SVSOG_RST_INERTIA;
            st.stat_n  <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign prdata              = st.rdata;
    assign pready              = st.rdy;
    assign pslverr             = st.err;
    assign fault_indicator_out = st.fault_o;
    assign status_out_n        = st.stat_n;
    assign irq                 = st.irq_o;
    assign position_loop_gain  = st.kp;
    assign speed_loop_gain     = st.kv;
    assign speed_integral_time = st.ti;
    assign load_inertia_ratio  = st.inert_o;

    // fault output rises with alarm entry, one cycle after fault_detect
    a_fault_entry: assert property (@(posedge mclk) disable iff (!rst_n)
        (!fault_indicator_out && fault_detect) |=> fault_indicator_out)
        else $error("fault output did not rise");

    // no leaving alarm while the cause stands
    a_fault_hold: assert property (@(posedge mclk) disable iff (!rst_n)
        (fault_indicator_out && fault_detect) |=> fault_indicator_out)
        else $error("fault cleared with cause present");

    // code 0 terminal tracks in_position inverted
    a_sel_inpos: assert property (@(posedge mclk) disable iff (!rst_n)
        (st.sel == `SVSOG_SEL_INPOS) ##1 (st.sel == `SVSOG_SEL_INPOS)
        |-> status_out_n == !$past(in_position))
        else $error("in-position terminal wrong");

    // code 1 running
    a_sel_run: assert property (@(posedge mclk) disable iff (!rst_n)
        (st.sel == `SVSOG_SEL_RUN && motor_speed > st.run_thr) |=> !status_out_n)
        else $error("running terminal not low");

    // code 3 clamp
    a_sel_clamp: assert property (@(posedge mclk) disable iff (!rst_n)
        (st.sel == `SVSOG_SEL_CLAMP && torque_cmd <= st.trq_lim) |=> status_out_n)
        else $error("clamp terminal not high");

    // code 5 index pulse
    a_sel_index: assert property (@(posedge mclk) disable iff (!rst_n)
        (st.sel == `SVSOG_SEL_INDEX) |=> status_out_n == !$past(idx_s))
        else $error("index terminal wrong");

    // code 7 energized
    a_sel_energy: assert property (@(posedge mclk) disable iff (!rst_n)
        (st.sel == `SVSOG_SEL_ENERGY && !st.ena) |=> status_out_n)
        else $error("energized terminal low while disabled");

    // code 9 torque detect
    a_sel_torque: assert property (@(posedge mclk) disable iff (!rst_n)
        (st.sel == `SVSOG_SEL_TRQ && torque_cmd > st.trq_thr) |=> !status_out_n)
        else $error("torque terminal not low");

    // gain relation holds one cycle after a stable setting
    a_gain_ratio: assert property (@(posedge mclk) disable iff (!rst_n)
        $stable(st.stf) && $stable(st.rat) |=>
        speed_loop_gain == 12'({3'h0, position_loop_gain} * ({10'h000, $past(st.rat)} + 12'h001)))
        else $error("speed gain not kp times ratio plus one");

    // level 15 endpoint of the table
    a_gain_top: assert property (@(posedge mclk) disable iff (!rst_n)
        (st.stf == 4'hF) |=> (position_loop_gain == 9'h12C && speed_integral_time == 10'h01E))
        else $error("level 15 gains wrong");

    // manual inertia drives the loop when tuning unsuitable
    a_inertia_man: assert property (@(posedge mclk) disable iff (!rst_n)
        !st.tune_ok |=> load_inertia_ratio == $past(st.inertia))
        else $error("manual inertia not used");

    // alarm with the cause gone and the clear pin seen
    sequence s_clear_taken;
        fault_indicator_out && !fault_detect && clr_s;
    endsequence

    // alarm leaves one cycle after an accepted clear
    a_fault_clear: assert property (@(posedge mclk) disable iff (!rst_n)
        s_clear_taken |=> !fault_indicator_out)
        else $error("fault output did not clear");

    // unassigned selector codes leave the terminal off
    a_sel_unused: assert property (@(posedge mclk) disable iff (!rst_n)
        !(st.sel inside {`SVSOG_SEL_INPOS, `SVSOG_SEL_RUN, `SVSOG_SEL_CLAMP,
                         `SVSOG_SEL_INDEX, `SVSOG_SEL_ENERGY, `SVSOG_SEL_TRQ}) |=> status_out_n)
        else $error("unused code drove terminal low");

    // bus error only flags the answering cycle
    a_err_ready: assert property (@(posedge mclk) disable iff (!rst_n)
        pslverr |-> pready)
        else $error("bus error without ready");
endmodule

// ---- verif/svsog_host.sv ----
/* host side model: drives the active-low fault clear pin.
   assumes: the bench asks for a clear; the cause input is the fault source. */
`timescale 1ns/100ps
module svsog_host (
    input  wire logic mclk,           // clock
    input  wire logic cause,          // fault cause still present
    input  wire logic clr_req,        // bench asks for a clear
    output logic      fault_clear_in  // clear pin, low = clear
);
    // pin rests released; the clear goes low only once the cause is gone
    always @(posedge mclk) fault_clear_in <= !(clr_req && !cause);
endmodule

// ---- verif/test_servo_status_outputs_and_gain_table.sv ----
/* bench of the status output and gain block: apb tasks, scenarios, verdict.
   assumes: svsog_top, svsog_host and the package compiled before it. */
`timescale 1ns/100ps
`include "svsog_regs.svh"
module test_servo_status_outputs_and_gain_table;
    logic mclk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, clr_req = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic fault_detect = 0, fault_clear_in, in_position = 0, index_pulse_in = 0;
    logic [15:0] torque_cmd = 0, motor_speed = 0, load_inertia_ratio;
    logic fault_indicator_out, status_out_n, irq, rd_err;
    logic [8:0] position_loop_gain;
    logic [11:0] speed_loop_gain;
    logic [9:0] speed_integral_time;
    int errors = 0, n_checks = 0;
    int kp_t[16] = '{10, 15, 20, 25, 30, 40, 65, 80, 100, 120, 140, 160, 180, 210, 250, 300};
    int ti_t[16] = '{800, 600, 450, 400, 300, 200, 140, 110, 90, 80, 70, 60, 55, 50, 40, 30};
    int sel_t[6] = '{0, 1, 3, 5, 7, 9};
    svsog_top i_svsog_top (.*);
    svsog_host i_svsog_host (.mclk(mclk), .cause(fault_detect), .clr_req(clr_req),
                             .fault_clear_in(fault_clear_in));
    always #2 mclk = ~mclk;  // 250 MHz
    // counts, verdict, end of run
    task automatic close_out;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk) penable <= 1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        rd = prdata;
        rd_err = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge mclk);
    endtask
    // level and ratio through the lookup
    task automatic gains;
        for (int l = 0; l < 16; l++) begin
            apb(1, `SVSOG_ADDR_CTRL, 32'h0 | (l % 4) << 8 | l << 4);
            repeat (3) @(posedge mclk);
            chk(position_loop_gain, kp_t[l], "kp");
            chk(speed_loop_gain, kp_t[l] * (l % 4 + 1), "kv");
            chk(speed_integral_time, ti_t[l], "ti");
        end
    endtask
    // each of the six assigned selector codes, condition true then false, speed and clamp off at their strict boundary
    task automatic selector;
        apb(1, `SVSOG_ADDR_RUN_THR, 32'h64);
        apb(1, `SVSOG_ADDR_TRQ_LIM, 32'hC8);
        apb(1, `SVSOG_ADDR_TRQ_THR, 32'h12C);
        for (int i = 0; i < 6; i++) begin
            apb(1, `SVSOG_ADDR_CTRL, 32'h750 | sel_t[i]);
            {in_position, index_pulse_in, motor_speed, torque_cmd} <= {2'b11, 16'h65, 16'h12D};
            repeat (5) @(posedge mclk);
            chk(status_out_n, 0, "on");
            apb(1, `SVSOG_ADDR_CTRL, 32'h350 | sel_t[i]);
            {in_position, index_pulse_in, motor_speed, torque_cmd} <= {2'b00, 16'h64, 16'hC8};
            repeat (5) @(posedge mclk);
            chk(status_out_n, 1, "off");
        end
        // an unassigned code keeps the terminal off with every condition true
        apb(1, `SVSOG_ADDR_CTRL, 32'h752);
        {in_position, index_pulse_in, motor_speed, torque_cmd} <= {2'b11, 16'h65, 16'h12D};
        repeat (5) @(posedge mclk);
        chk(status_out_n, 1, "unused code");
    endtask
    // fault entry, clear request held off at the pin by the host while the cause stands, masked and unmasked interrupt, clear
    task automatic fault;
        fault_detect <= 1;
        clr_req <= 1;
        repeat (6) @(posedge mclk);
        chk({fault_indicator_out, irq}, 2'b10, "alarm, masked");
        apb(1, `SVSOG_ADDR_IRQ_MASK, 32'h1);
        chk(irq, 1, "irq");
        fault_detect <= 0;
        repeat (8) @(posedge mclk);
        chk(fault_indicator_out, 0, "cleared");
        clr_req <= 0;
        apb(1, `SVSOG_ADDR_IRQ_STAT, 32'h1);
        chk(irq, 0, "w1c");
        apb(1, `SVSOG_ADDR_INERTIA, 32'h1234);
        repeat (3) @(posedge mclk);
        chk(load_inertia_ratio, 16'h1234, "manual inertia");
    endtask
    initial begin
        repeat (16) @(posedge mclk);
        rst_n <= 1;
        @(posedge mclk);
        apb(0, `SVSOG_ADDR_CTRL, 0);
        chk(rd[9:0], 10'h350, "ctrl reset");
        chk(rd_err, 0, "mapped no error");
        chk(position_loop_gain, 40, "kp reset");
        apb(0, 12'h030, 0);
        chk(rd, 0, "unmapped");
        chk(rd_err, 1, "unmapped error");
        gains;
        selector;
        fault;
        close_out;
    end
    // cut a hang short
    initial begin
        repeat (20000) @(posedge mclk);
        errors++;
        close_out;
    end
endmodule
